/* File: include/adc_cfg_pkg.sv */
package adc_cfg_pkg;
	localparam logic [7:0] addr_readback_timing = 8'h04;
	localparam logic [7:0] addr_scrambler_ctrl = 8'h07;
	localparam logic [7:0] addr_calib_delay = 8'h1E;
	localparam logic [7:0] addr_delay_loop_ctrl = 8'h52;
	localparam logic [7:0] rst_readback_timing = 8'h9F;
	localparam logic [7:0] rst_scrambler_ctrl = 8'h62;
	localparam logic [7:0] rst_calib_delay = 8'h80;
	localparam logic [7:0] rst_delay_loop_ctrl = 8'h0A;
	localparam int bit_sdo_edge = 7;
	localparam int bit_wclk_invert = 7;
	localparam int bit_calib_enable = 6;
	localparam int bit_scramble = 0;
	localparam int bit_duty_corr = 7;
	localparam int bit_phase_hi = 6;
	localparam int bit_phase_lo = 4;
	localparam int bit_loop_clk_en = 3;
	localparam int bit_loop_en = 2;
	localparam int bit_clk_buf_en = 1;
	localparam int bit_loop_run = 0;
	localparam logic [2:0] phase_default = 3'h0;
endpackage

/* File: hw/adc_clock_and_output_config_regs.sv */
// Notes on behaviour
// RQ1: Bit 7 at 0x04 picks readback launch edge; 1 falling, 0 rising.
// RQ2: Host keeps all factory bits at their reset values.
// RQ3: Bit 7 at 0x07 inverts word clock, only in down conversion mode.
// RQ4: Bit 6 at 0x07 enables calibration delay; setting used only when set.
// RQ5: Bit 0 at 0x07 scrambles converter output data when set.
// RQ6: 0x1E holds eight-bit calibration start delay, linear, reset 0x80.
// RQ7: Bit 7 at 0x52 turns on input clock duty correction.
// RQ8: Bits 6:4 at 0x52 shift output clock phase in 45 degree steps.
// RQ9: Phase field acts only with phase delay enabled and no decimation.
// RQ10: Bit 3 at 0x52 keeps loop output clock running; 0 stops it.
// RQ11: Bit 2 at 0x52 enables the selectable-phase delay loop.
// RQ12: Bit 1 at 0x52 enables the clock input buffer; 0 kills clocks.
// RQ13: Bit 0 at 0x52 holds the delay loop in reset while 0.
// RQ14: Host resets the loop by writing run 0 then 1.
// RQ15: Writable bits read back last write; defaults restored on reset.
//
// Decided for this implementation: strobed register access.
module adc_clock_and_output_config_regs
	import adc_cfg_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic down_conversion,
	input wire logic phase_delay_enable,
	input wire logic decimation_used,
	output logic sdo_edge_select,
	output logic word_clock_invert,
	output logic output_scramble_enable,
	output logic calib_delay_enable,
	output logic [7:0] calib_start_delay,
	output logic duty_correction_enable,
	output logic [2:0] out_clock_phase_sel,
	output logic delay_loop_out_clock_enable,
	output logic delay_loop_enable,
	output logic clock_input_buffer_enable,
	output logic delay_loop_run
);
	// Stored register images
	logic [7:0] timing_q;
	logic [7:0] scram_q;
	logic [7:0] cdelay_q;
	logic [7:0] loop_q;
	// Read path
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	// Mode strap synchronisers
	logic dc_s1_q;
	logic dc_s2_q;
	logic pd_s1_q;
	logic pd_s2_q;
	logic dm_s1_q;
	logic dm_s2_q;
	// Next values of the configuration outputs
	logic sdo_d;
	logic wclk_inv_d;
	logic scram_out_d;
	logic cal_en_d;
	logic [7:0] cdelay_d;
	logic duty_d;
	logic [2:0] phase_d;
	logic lclk_d;
	logic len_d;
	logic buf_d;
	logic run_d;
	// Configuration output flops
	logic sdo_q;
	logic wclk_inv_q;
	logic scram_out_q;
	logic cal_en_q;
	logic [7:0] cdelay_out_q;
	logic duty_q;
	logic [2:0] phase_q;
	logic lclk_q;
	logic len_q;
	logic buf_q;
	logic run_q;
	// Address decode
	logic hit_timing;
	logic hit_scram;
	logic hit_cdelay;
	logic hit_loop;
	logic wr_timing;
	logic wr_scram;
	logic wr_cdelay;
	logic wr_loop;
	logic phase_allowed;

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	assign hit_timing = addr_hit(addr, addr_readback_timing);
	assign hit_scram = addr_hit(addr, addr_scrambler_ctrl);
	assign hit_cdelay = addr_hit(addr, addr_calib_delay);
	assign hit_loop = addr_hit(addr, addr_delay_loop_ctrl);
	// Writes to unmapped addresses fall on the floor
	assign wr_timing = wr_en && hit_timing;
	assign wr_scram = wr_en && hit_scram;
	assign wr_cdelay = wr_en && hit_cdelay;
	assign wr_loop = wr_en && hit_loop;

	// Unmapped addresses read as zero
	always_comb begin
		rdata_d = 8'h00;
		if (hit_timing) rdata_d = timing_q; // RQ15
		if (hit_scram) rdata_d = scram_q;
		if (hit_cdelay) rdata_d = cdelay_q;
		if (hit_loop) rdata_d = loop_q;
	end

	assign sdo_d = timing_q[bit_sdo_edge]; // RQ1
	// Inversion only means something in down conversion mode
	assign wclk_inv_d = scram_q[bit_wclk_invert] & dc_s2_q; // RQ3
	assign scram_out_d = scram_q[bit_scramble]; // RQ5
	assign cal_en_d = scram_q[bit_calib_enable]; // RQ4
	// Without the enable the delay counter runs at its default code
	assign cdelay_d = cal_en_d ? cdelay_q : rst_calib_delay; // RQ4
	assign duty_d = loop_q[bit_duty_corr]; // RQ7
	// Phase shift ignored unless delay path active and no decimation
	assign phase_allowed = pd_s2_q && !dm_s2_q; // RQ9
	assign phase_d = phase_allowed ? loop_q[bit_phase_hi:bit_phase_lo] : phase_default; // RQ8
	assign lclk_d = loop_q[bit_loop_clk_en]; // RQ10
	assign len_d = loop_q[bit_loop_en]; // RQ11
	assign buf_d = loop_q[bit_clk_buf_en]; // RQ12
	assign run_d = loop_q[bit_loop_run]; // RQ13

	// Factory bits stored as written; host must leave them alone
	always_ff @(posedge clock) begin
		if (rst) begin
			timing_q <= rst_readback_timing;
		end else if (wr_timing) begin
			timing_q <= wdata; // RQ15
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			scram_q <= rst_scrambler_ctrl;
		end else if (wr_scram) begin
			scram_q <= wdata; // RQ15
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cdelay_q <= rst_calib_delay;
		end else if (wr_cdelay) begin
			cdelay_q <= wdata; // RQ6
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			loop_q <= rst_delay_loop_ctrl;
		end else if (wr_loop) begin
			loop_q <= wdata; // RQ15
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_en ? rdata_d : 8'h00;
		end
	end

	// Mode straps come from other clock regions
	always_ff @(posedge clock) begin
		if (rst) begin
			dc_s1_q <= 1'b0;
			dc_s2_q <= 1'b0;
		end else begin
			dc_s1_q <= down_conversion;
			dc_s2_q <= dc_s1_q;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pd_s1_q <= 1'b0;
			pd_s2_q <= 1'b0;
		end else begin
			pd_s1_q <= phase_delay_enable;
			pd_s2_q <= pd_s1_q;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dm_s1_q <= 1'b0;
			dm_s2_q <= 1'b0;
		end else begin
			dm_s1_q <= decimation_used;
			dm_s2_q <= dm_s1_q;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sdo_q <= rst_readback_timing[bit_sdo_edge];
		end else begin
			sdo_q <= sdo_d; // RQ1
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wclk_inv_q <= 1'b0;
		end else begin
			wclk_inv_q <= wclk_inv_d; // RQ3
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			scram_out_q <= rst_scrambler_ctrl[bit_scramble];
		end else begin
			scram_out_q <= scram_out_d; // RQ5
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cal_en_q <= rst_scrambler_ctrl[bit_calib_enable];
		end else begin
			cal_en_q <= cal_en_d; // RQ4
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cdelay_out_q <= rst_calib_delay;
		end else begin
			cdelay_out_q <= cdelay_d; // RQ6
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			duty_q <= rst_delay_loop_ctrl[bit_duty_corr];
		end else begin
			duty_q <= duty_d; // RQ7
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			phase_q <= phase_default;
		end else begin
			phase_q <= phase_d; // RQ8
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			lclk_q <= rst_delay_loop_ctrl[bit_loop_clk_en];
		end else begin
			lclk_q <= lclk_d; // RQ10
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			len_q <= rst_delay_loop_ctrl[bit_loop_en];
		end else begin
			len_q <= len_d; // RQ11
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			buf_q <= rst_delay_loop_ctrl[bit_clk_buf_en];
		end else begin
			buf_q <= buf_d; // RQ12
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			run_q <= rst_delay_loop_ctrl[bit_loop_run];
		end else begin
			run_q <= run_d; // RQ13
		end
	end

	assign rdata = rdata_q;
	assign sdo_edge_select = sdo_q;
	assign word_clock_invert = wclk_inv_q;
	assign output_scramble_enable = scram_out_q;
	assign calib_delay_enable = cal_en_q;
	assign calib_start_delay = cdelay_out_q;
	assign duty_correction_enable = duty_q;
	assign out_clock_phase_sel = phase_q;
	assign delay_loop_out_clock_enable = lclk_q;
	assign delay_loop_enable = len_q;
	assign clock_input_buffer_enable = buf_q;
	assign delay_loop_run = run_q;
endmodule

/* File: bench/adc_cfg_regs_chk.sv */
module adc_cfg_regs_chk
	import adc_cfg_pkg::*;
(
	input wire logic clock, rst, wr_en, rd_en, down_conversion, phase_delay_enable,
	input wire logic decimation_used, sdo_edge_select, word_clock_invert,
	input wire logic output_scramble_enable, calib_delay_enable, duty_correction_enable,
	input wire logic delay_loop_out_clock_enable, delay_loop_enable,
	input wire logic clock_input_buffer_enable, delay_loop_run,
	input wire logic [7:0] addr, wdata, rdata, calib_start_delay,
	input wire logic [2:0] out_clock_phase_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence wr_at(logic [7:0] a); wr_en && addr == a; endsequence
	AST_SDO_EDGE: assert property (wr_at(addr_readback_timing) |-> ##2
		sdo_edge_select == $past(wdata[7], 2)) else $error("sdo edge wrong");
	AST_WCLK_GATE: assert property ((!down_conversion)[*5] |-> !word_clock_invert)
		else $error("word clock inverted outside down conversion");
	AST_WCLK_SET: assert property (down_conversion[*5] ##0 wr_at(addr_scrambler_ctrl) ##1
		down_conversion[*2] |-> word_clock_invert == $past(wdata[7], 2))
		else $error("word clock polarity wrong");
	AST_CAL_FALLBACK: assert property (!calib_delay_enable |->
		calib_start_delay == rst_calib_delay) else $error("delay used while disabled");
	AST_SCRAMBLE: assert property (wr_at(addr_scrambler_ctrl) |-> ##2
		output_scramble_enable == $past(wdata[0], 2) && calib_delay_enable == $past(wdata[6], 2))
		else $error("scrambler control wrong");
	AST_DELAY_VALUE: assert property (wr_at(addr_calib_delay) ##2 calib_delay_enable |->
		calib_start_delay == $past(wdata, 2)) else $error("calibration delay wrong");
	AST_LOOP_CTRL: assert property (wr_at(addr_delay_loop_ctrl) |-> ##2
		{duty_correction_enable, delay_loop_out_clock_enable, delay_loop_enable,
		clock_input_buffer_enable, delay_loop_run} == {$past(wdata[7], 2), $past(wdata[3:0], 2)})
		else $error("loop control wrong");
	AST_PHASE_GATE: assert property ((!phase_delay_enable || decimation_used)[*5] |->
		out_clock_phase_sel == phase_default) else $error("phase applied while gated");
	AST_PHASE_SEL: assert property ((phase_delay_enable && !decimation_used)[*6] ##0
		wr_at(addr_delay_loop_ctrl) ##1 (phase_delay_enable && !decimation_used)[*2] |->
		out_clock_phase_sel == $past(wdata[6:4], 2)) else $error("phase select wrong");
	AST_RD_IDLE: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
endmodule
bind adc_clock_and_output_config_regs adc_cfg_regs_chk u_chk (.*);

/* File: bench/host_model.sv */
module host_model
	import adc_cfg_pkg::*;
(
	input wire logic clock,
	input wire logic [7:0] rdata,
	output logic [7:0] addr, wdata,
	output logic wr_en, rd_en
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {addr, wdata, wr_en, rd_en} = 18'h0;
	function automatic logic [7:0] keep(input logic [7:0] a, d);
		case (a)
			addr_readback_timing: return (d & 8'h80) | (rst_readback_timing & 8'h7F);
			addr_scrambler_ctrl: return (d & 8'hC1) | (rst_scrambler_ctrl & 8'h3E);
			default: return d;
		endcase
	endfunction
	// Released lines flip so stale values never pass as held
	task automatic write(input logic [7:0] a, d);
		@(posedge clock);
		{addr, wdata, wr_en} <= {a, keep(a, d), 1'b1};
		@(posedge clock);
		{addr, wdata, wr_en} <= {~a, ~keep(a, d), 1'b0};
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] q);
		@(posedge clock);
		{addr, rd_en} <= {a, 1'b1};
		@(posedge clock);
		{addr, rd_en} <= {~a, 1'b0};
		#1 q = rdata;
	endtask
endmodule

/* File: bench/adc_clock_and_output_config_regs_tb_top.sv */
module adc_clock_and_output_config_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_cfg_pkg::*;
	logic clock = 0, rst = 1, down_conversion = 0, phase_delay_enable = 0, decimation_used = 0;
	logic wr_en, rd_en, sdo_edge_select, word_clock_invert, output_scramble_enable;
	logic calib_delay_enable, duty_correction_enable, delay_loop_out_clock_enable;
	logic delay_loop_enable, clock_input_buffer_enable, delay_loop_run;
	logic [7:0] addr, wdata, rdata, calib_start_delay, q, d, a;
	logic [2:0] out_clock_phase_sel;
	logic [7:0] regs [4] = '{addr_readback_timing, addr_scrambler_ctrl, addr_calib_delay,
		addr_delay_loop_ctrl};
	logic [7:0] rsts [4] = '{rst_readback_timing, rst_scrambler_ctrl, rst_calib_delay,
		rst_delay_loop_ctrl};
	int mismatches = 0, check_count = 0;
	integer seed = 32'h98e6c079;
	always #20 clock = ~clock;
	adc_clock_and_output_config_regs u_adc_clock_and_output_config_regs (.*);
	host_model u_host_model (.*);
	task automatic check(input logic [7:0] got, exp);
		check_count++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask
	task automatic complete_run;
		$display("mismatches=%0d checks=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#100000 mismatches++;
		complete_run;
	end
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			u_host_model.read(regs[i], q);
			check(q, rsts[i]);
		end
		for (int i = 0; i < 32; i++) begin
			a = (i == 21) ? 8'h05 : regs[$unsigned($random(seed)) % 4];
			d = $random(seed);
			u_host_model.write(a, d);
			u_host_model.read(a, q);
			check(q, (a == 8'h05) ? 8'h00 : u_host_model.keep(a, d));
			@(posedge clock);
			// Modes held for several writes so the phase path gets exercised
			if (i % 4 == 0)
				{down_conversion, phase_delay_enable, decimation_used} <= (i == 4) ? 3'h6 : d[3:1];
		end
		u_host_model.write(addr_delay_loop_ctrl, 8'h0E);
		@(posedge clock);
		#1 check({7'h00, delay_loop_run}, 8'h00);
		u_host_model.write(addr_delay_loop_ctrl, 8'h0F);
		@(posedge clock);
		#1 check({7'h00, delay_loop_run}, 8'h01);
		u_host_model.write(addr_readback_timing, 8'h1F);
		@(posedge clock);
		#1 check({7'h00, sdo_edge_select}, 8'h00);
		complete_run;
	end
endmodule
